// ### pot_transfer_and_step_commands_test.sv
`timescale 1ns/1ps
`default_nettype none
module pot_transfer_and_step_commands_test;
  logic       clk_sys = 1'b0;
  logic       rstn = 1'b0;
  logic       cs_n;
  logic       sck;
  logic       si;
  logic [7:0] w0;
  logic [7:0] w1;
  logic       busy;
  logic [1:0] strap = 2'b10;
  int         bad_count = 0;
  int         checks = 0;
  always #5 clk_sys = ~clk_sys;
  spi_host_model u_spi_host_model (
    .clk_sys(clk_sys), .cs_n(cs_n), .sck(sck), .si(si));
  pot_xfer_step #(.NV_CYCLES(50)) u_pot_xfer_step (
    .clk_sys(clk_sys), .rstn(rstn), .cs_n(cs_n), .sck(sck), .si(si),
    .dev_select_hi(strap[1]), .dev_select_lo(strap[0]),
    .wiper_position_reg0_r(w0), .wiper_position_reg1_r(w1),
    .nv_write_busy_flag(busy));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("FAIL %0t saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic cmd(input logic [7:0] adr, input logic [7:0] op,
                     input int n, input logic [7:0] dir);
    u_spi_host_model.frame({adr, op}, n, dir);
  endtask
  task automatic nv_wait;
    int i;
    check({7'h00, busy}, 8'h01);
    for (i = 0; i < 60 && busy !== 1'b0; i++) @(posedge clk_sys);
    check({7'h00, busy}, 8'h00);
    if (busy !== 1'b0) finish_test();
  endtask
  initial begin
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (4) @(posedge clk_sys);
    cmd(8'h52, 8'h20, 5, 8'h1F);
    check(w0, 8'h05);
    cmd(8'h52, 8'h20, 2, 8'h00);
    check(w0, 8'h03);
    cmd(8'h52, 8'h21, 7, 8'h7F);
    check(w1, 8'h07);
    check(w0, 8'h03);
    cmd(8'h52, 8'h84, 0, 8'h00);
    nv_wait();
    cmd(8'h52, 8'h20, 1, 8'h01);
    check(w0, 8'h04);
    cmd(8'h52, 8'hE8, 0, 8'h00);
    nv_wait();
    cmd(8'h51, 8'h21, 3, 8'h00);
    check(w1, 8'h07);
    cmd(8'h52, 8'h21, 3, 8'h00);
    check(w1, 8'h04);
    cmd(8'h52, 8'h20, 2, 8'h00);
    check(w0, 8'h02);
    cmd(8'h52, 8'hD8, 0, 8'h00);
    check(w0, 8'h04);
    check({7'h00, busy}, 8'h00);
    cmd(8'h52, 8'h14, 0, 8'h00);
    check(w0, 8'h03);
    check(w1, 8'h07);
    cmd(8'h52, 8'hED, 0, 8'h00);
    nv_wait();
    cmd(8'h52, 8'h21, 2, 8'h00);
    check(w1, 8'h05);
    cmd(8'h52, 8'hDD, 0, 8'h00);
    check(w1, 8'h07);
    check(w0, 8'h03);
    strap <= 2'b01;
    cmd(8'h52, 8'h20, 1, 8'h01);
    check(w0, 8'h03);
    cmd(8'h51, 8'h20, 1, 8'h01);
    check(w0, 8'h04);
    finish_test();
  end
endmodule // pot_transfer_and_step_commands_test
`default_nettype wire

// ### pot_xfer_checks_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module pot_xfer_checks #(
  parameter NV_CYCLES = 50
) (
  input wire logic       clk_sys,
  input wire logic       rstn,
  input wire logic       cs_n,
  input wire logic [7:0] wiper_position_reg0_r,
  input wire logic [7:0] wiper_position_reg1_r,
  input wire logic       nv_write_busy_flag
);
  int bcnt_r;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  always @(posedge clk_sys) begin
    if (!rstn || !nv_write_busy_flag) bcnt_r <= 0;
    else bcnt_r <= bcnt_r + 1;
  end
  AST_NV_AFTER_CS: assert property (
    $rose(nv_write_busy_flag) |-> cs_n && $past(cs_n, 2))
    else $error("busy rose inside a frame");
  AST_NV_CAUSE: assert property (
    $rose(nv_write_busy_flag) |-> !$past(cs_n, 8))
    else $error("busy rose without a frame end");
  AST_BUSY_HOLD: assert property (
    $rose(nv_write_busy_flag) |=> nv_write_busy_flag[*8])
    else $error("busy dropped early");
  AST_BUSY_MAX: assert property (bcnt_r <= NV_CYCLES + 1)
    else $error("busy too long");
  AST_BUSY_MIN: assert property (
    $fell(nv_write_busy_flag) && $past(rstn) |-> bcnt_r >= NV_CYCLES - 1)
    else $error("busy too short");
  AST_BUSY_GAP: assert property (
    $fell(nv_write_busy_flag) |=> !nv_write_busy_flag[*8])
    else $error("busy restarted without frame");
  AST_W0_IDLE: assert property (
    cs_n[*6] |-> $stable(wiper_position_reg0_r))
    else $error("wiper 0 moved outside a frame");
  AST_W1_IDLE: assert property (
    cs_n[*6] |-> $stable(wiper_position_reg1_r))
    else $error("wiper 1 moved outside a frame");
endmodule // pot_xfer_checks
bind pot_xfer_step pot_xfer_checks #(.NV_CYCLES(NV_CYCLES)) u_pot_xfer_checks (
  .clk_sys(clk_sys), .rstn(rstn), .cs_n(cs_n),
  .wiper_position_reg0_r(wiper_position_reg0_r),
  .wiper_position_reg1_r(wiper_position_reg1_r),
  .nv_write_busy_flag(nv_write_busy_flag));
`default_nettype wire

// ### pot_xfer_regs.vh
`ifndef POT_XFER_REGS_VH
`define POT_XFER_REGS_VH
`define ADDR_PREFIX       6'b01_0100
`define OP_GLOBAL_LOAD    4'b0001
`define OP_GLOBAL_STORE   4'b1000
`define OP_STORE_ONE      4'b1110
`define OP_LOAD_ONE       4'b1101
`define OP_STEP           6'b00_1000
`define NV_WRITE_MS       5
`define CLK_KHZ           100000
`define NV_WRITE_CYCLES   (`NV_WRITE_MS * `CLK_KHZ)
`define WIPER_RESET       8'h00
`endif

// ### pot_xfer_step.v
`timescale 1ns/1ps
`default_nettype none
`include "pot_xfer_regs.vh"
module pot_xfer_step #(
  parameter NV_CYCLES = `NV_WRITE_CYCLES
) (
  input  wire       clk_sys,
  input  wire       rstn,
  input  wire       cs_n,
  input  wire       sck,
  input  wire       si,
  input  wire       dev_select_hi,
  input  wire       dev_select_lo,
  output reg  [7:0] wiper_position_reg0_r,
  output reg  [7:0] wiper_position_reg1_r,
  output reg        nv_write_busy_flag
);
  localparam S_IDLE = 3'd0;
  localparam S_ADDR = 3'd1;
  localparam S_INST = 3'd2;
  localparam S_STEP = 3'd3;
  localparam S_DONE = 3'd4;
  localparam S_IGN  = 3'd5;

  reg [2:0] cs_s, sck_s, si_s;
  reg [1:0] strap_s0, strap_s1;
  reg [2:0] st_r;
  reg [2:0] cnt_r;
  reg [7:0] sh_r;
  reg [1:0] bank_r;
  reg       pot_r;
  reg       glob_r;
  reg       nv_pend_r;
  reg [1:0] nv_todo_r;
  reg [22:0] timer_r;
  reg [2:0] mem_op_r;
  reg [2:0] raddr;
  reg [2:0] waddr;
  reg [7:0] wdata;
  reg       we;
  wire [7:0] rdata;

  wire cs_low  = ~cs_s[1];
  wire cs_rise = cs_s[1] & ~cs_s[2];
  wire sck_up  = sck_s[1] & ~sck_s[2];
  wire bit_in  = si_s[1];
  wire [7:0] byte_in = {sh_r[6:0], bit_in};

  // pin inputs: two flops before use; strap caught through synchroniser
  // reset to idle levels so no false cs or sck edge follows reset
  always @(posedge clk_sys) begin
    if (!rstn) begin
      cs_s  <= 3'b111;
      sck_s <= 3'b000;
      si_s  <= 3'b000;
    end else begin
      cs_s  <= {cs_s[1:0], cs_n};
      sck_s <= {sck_s[1:0], sck};
      si_s  <= {si_s[1:0], si};
    end
    strap_s0 <= {dev_select_hi, dev_select_lo};
    strap_s1 <= strap_s0;
  end

  saved_setting_mem #(.AW(3), .DW(8)) u_mem (
    .clk_sys (clk_sys),
    .we      (we),
    .waddr   (waddr),
    .wdata   (wdata),
    .raddr   (raddr),
    .rdata_r (rdata)
  );

  // mem_op_r: 1/2 load pot0/pot1 (read issued, data next), 3/4 capture
  always @* begin
    raddr = {pot_r, bank_r};
    if (mem_op_r == 3'd1) begin
      raddr = {1'b0, bank_r};
    end else if (mem_op_r == 3'd2) begin
      raddr = {1'b1, bank_r};
    end
  end

  // store into array on cs rise; a global store writes pot1 one cycle after the cs rise
  always @* begin
    we    = 1'b0;
    waddr = {pot_r, bank_r};
    wdata = pot_r ? wiper_position_reg1_r : wiper_position_reg0_r;
    if (cs_rise && nv_pend_r) begin
      we = nv_todo_r[0] | nv_todo_r[1];
      if (nv_todo_r == 2'b11) begin
        waddr = {1'b0, bank_r};
        wdata = wiper_position_reg0_r;
      end
    end else if (nv_todo_r == 2'b10 && nv_write_busy_flag && !nv_pend_r) begin
      we    = 1'b1;
      waddr = {1'b1, bank_r};
      wdata = wiper_position_reg1_r;
    end
  end

  always @(posedge clk_sys) begin
    if (!rstn) begin
      st_r <= S_IDLE;
      cnt_r <= 3'd0;
      sh_r <= 8'h00;
      bank_r <= 2'd0;
      pot_r <= 1'b0;
      glob_r <= 1'b0;
      nv_pend_r <= 1'b0;
      nv_todo_r <= 2'b00;
      timer_r <= 23'd0;
      mem_op_r <= 3'd0;
      nv_write_busy_flag <= 1'b0;
      wiper_position_reg0_r <= `WIPER_RESET;
      wiper_position_reg1_r <= `WIPER_RESET;
    end else begin
      // volatile loads: one cycle for read, one for capture
      case (mem_op_r)
        3'd1: mem_op_r <= 3'd3;
        3'd2: mem_op_r <= 3'd4;
        3'd3: begin
          wiper_position_reg0_r <= rdata;
          mem_op_r <= glob_r ? 3'd2 : 3'd0;
        end
        3'd4: begin
          wiper_position_reg1_r <= rdata;
          mem_op_r <= 3'd0;
        end
        default: mem_op_r <= 3'd0;
      endcase
      // programming cycle
      if (cs_rise && nv_pend_r) begin
        nv_pend_r <= 1'b0;
        nv_write_busy_flag <= 1'b1;
        timer_r <= NV_CYCLES[22:0] - 23'd1;
        nv_todo_r <= (nv_todo_r == 2'b11) ? 2'b10 : 2'b00;
      end else if (nv_write_busy_flag) begin
        if (nv_todo_r == 2'b10) begin
          nv_todo_r <= 2'b00;
        end
        if (timer_r == 23'd0) begin
          nv_write_busy_flag <= 1'b0;
        end else begin
          timer_r <= timer_r - 23'd1;
        end
      end
      if (!cs_low) begin
        st_r <= S_IDLE;
      end else begin
        case (st_r)
          S_IDLE: begin
            st_r <= S_ADDR;
            cnt_r <= 3'd0;
            nv_pend_r <= 1'b0;
          end
          S_ADDR, S_INST: begin
            if (sck_up) begin
              sh_r <= byte_in;
              cnt_r <= cnt_r + 3'd1;
              if (cnt_r == 3'd7) begin
                if (st_r == S_ADDR) begin
                  // wrong address: drop frame
                  if (byte_in[7:2] == `ADDR_PREFIX && byte_in[1:0] == strap_s1)
                    st_r <= S_INST;
                  else
                    st_r <= S_IGN;
                end else begin
                  st_r <= S_DONE;
                  bank_r <= byte_in[3:2];
                  pot_r <= byte_in[0];
                  glob_r <= 1'b0;
                  if (byte_in[7:4] == `OP_GLOBAL_LOAD && byte_in[1:0] == 2'b00
                      && !nv_write_busy_flag) begin
                    glob_r <= 1'b1;
                    mem_op_r <= 3'd1;
                  end else if (byte_in[7:4] == `OP_LOAD_ONE
                               && !nv_write_busy_flag) begin
                    mem_op_r <= byte_in[0] ? 3'd2 : 3'd1;
                  end else if (byte_in[7:4] == `OP_GLOBAL_STORE
                               && byte_in[1:0] == 2'b00
                               && !nv_write_busy_flag) begin
                    nv_pend_r <= 1'b1;
                    nv_todo_r <= 2'b11;
                  end else if (byte_in[7:4] == `OP_STORE_ONE
                               && !nv_write_busy_flag) begin
                    nv_pend_r <= 1'b1;
                    nv_todo_r <= 2'b01;
                  end else if (byte_in[7:2] == `OP_STEP) begin
                    st_r <= S_STEP;
                  end
                end
              end
            end
          end
          S_STEP: begin
            // saturate at ends; up toward high terminal
            if (sck_up) begin
              if (!pot_r) begin
                if (bit_in && wiper_position_reg0_r != 8'hFF)
                  wiper_position_reg0_r <= wiper_position_reg0_r + 8'h01;
                else if (!bit_in && wiper_position_reg0_r != 8'h00)
                  wiper_position_reg0_r <= wiper_position_reg0_r - 8'h01;
              end else begin
                if (bit_in && wiper_position_reg1_r != 8'hFF)
                  wiper_position_reg1_r <= wiper_position_reg1_r + 8'h01;
                else if (!bit_in && wiper_position_reg1_r != 8'h00)
                  wiper_position_reg1_r <= wiper_position_reg1_r - 8'h01;
              end
            end
          end
          default: st_r <= st_r;
        endcase
      end
    end
  end
endmodule // pot_xfer_step
`default_nettype wire

// ### saved_setting_mem.v
`timescale 1ns/1ps
`default_nettype none
module saved_setting_mem #(
  parameter AW = 3,
  parameter DW = 8
) (
  input  wire          clk_sys,
  input  wire          we,
  input  wire [AW-1:0] waddr,
  input  wire [DW-1:0] wdata,
  input  wire [AW-1:0] raddr,
  output reg  [DW-1:0] rdata_r
);
  reg [DW-1:0] mem [0:(1<<AW)-1];
  // contents stand for non-volatile cells: no reset
  always @(posedge clk_sys) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata_r <= mem[raddr];
  end
endmodule // saved_setting_mem
`default_nettype wire

// ### spi_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
  input  wire logic clk_sys,
  output var  logic cs_n,
  output var  logic sck,
  output var  logic si
);
  initial begin
    cs_n = 1'b1;
    sck  = 1'b0;
    si   = 1'b0;
  end
  // sck runs at eight clocks a bit, and stands low between frames
  task automatic frame(input logic [15:0] hdr, input int n,
                       input logic [7:0] dir);
    int i;
    cs_n <= 1'b0;
    repeat (4) @(posedge clk_sys);
    for (i = 0; i < 16 + n; i++) begin
      si <= (i < 16) ? hdr[15 - i] : dir[i - 16];
      repeat (4) @(posedge clk_sys);
      sck <= 1'b1;
      repeat (4) @(posedge clk_sys);
      sck <= 1'b0;
    end
    repeat (4) @(posedge clk_sys);
    cs_n <= 1'b1;
    // released line must not keep the last bit
    si   <= ~si;
    repeat (8) @(posedge clk_sys);
  endtask
endmodule // spi_host_model
`default_nettype wire
